// ===== fpnvm_top.sv
// Purpose: lock, security, config and calibration nv bits of a flash
// Assumes: nv cell array outside restores bits after reset, keeps writes
// Notes: APB slave, one wait state per access
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps

// Behaviour
// - each controller holds 16 lock bits; two controllers give 32 regions.
// - lock bit guards 64 pages of 256 bytes, 16 Kbytes per region.
// - program or erase on locked region aborts untouched and raises interrupt.
// - set-lock sets the region's lock bit; clear-lock clears it.
// - all 32 lock bits reachable through the command interface.
// - chip-wipe pin clears every lock bit.
// - security set refuses all debug and fast programming accesses.
// - only set-security sets security; no command clears it.
// - security clears only after wipe pin high and full erase done.
// - config bits set and cleared singly, kept across power loss.
// - config bit 0 enables brownout detector; wipe clears it.
// - config bit 1 enables brownout reset; wipe clears it.
// - eight calibration bits read-only, untouched by wipe.
// - fast programming mode only with test pin and port lines 0, 1 high.
// - fast port takes read, program, erase, full erase, lock, unlock, protect.
// - boot from flash when config bit 2 is 1, else boot rom at 0x0.
// - wipe clears config bit 2, selecting rom boot.
module fpnvm_top import fpnvm_pkg::*; #(
  parameter int NUM_CTRL = NUM_CTRL_DEF,
  parameter int WIPE_CYC = ERASE_HOLD_CYC,
  localparam int LOCKS = NUM_CTRL * LOCKS_PER_CTRL,
  localparam int LW = $clog2(LOCKS),
  localparam int PW = LW + REG_SHIFT
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // pins
  input wire logic erase_pin,
  input wire logic test_mode_pin,
  input wire logic port_a_line_zero,
  input wire logic port_a_line_one,
  // nv cell array
  input wire logic [LOCKS-1:0] nv_lock_in,
  input wire logic [GP_BITS-1:0] nv_gp_in,
  input wire logic nv_sec_in,
  input wire logic [CALIB_BITS-1:0] nv_calib_in,
  output logic [LOCKS-1:0] lock_bits,
  output logic [GP_BITS-1:0] general_config_nv_bit,
  output logic security_bit,
  output logic [CALIB_BITS-1:0] calib_bits,
  // system controls
  output logic brownout_detector_en,
  output logic brownout_reset_en,
  output logic boot_from_flash,
  // flash array operations
  output logic flash_prog,
  output logic flash_erase,
  output logic flash_full_erase,
  output logic [PW-1:0] flash_page,
  input wire logic flash_done,
  // in_circuit_debug_port access check
  input wire logic dbg_req,
  output logic dbg_ack,
  output logic dbg_deny,
  // fast_programming_port
  input wire logic ffp_req,
  input wire logic [2:0] ffp_cmd,
  input wire logic [PW-1:0] ffp_arg,
  output logic ffp_ack,
  output logic ffp_deny,
  output logic ffp_mode
);
  // ==========================================================
  // parameter checks
  localparam int CW = $clog2(WIPE_CYC + 1);
  localparam logic [CW-1:0] WIPE_MAX = CW'(WIPE_CYC);

  if (NUM_CTRL < 1 || NUM_CTRL > 2) begin : g_bad_ctrl
    $error("NUM_CTRL must be 1 or 2");
  end
  if (WIPE_CYC < 1) begin : g_bad_wipe
    $error("WIPE_CYC must be at least 1");
  end

  // ==========================================================
  // state
  typedef struct packed {
    fpnvm_state_t st;
    logic [LOCKS-1:0] lock;
    logic [GP_BITS-1:0] gp;
    logic sec;
    logic [CALIB_BITS-1:0] calib;
    logic [2:0] ers_s;
    logic ers_lvl;
    logic [2:0][2:0] pin_s;
    logic mode;
    logic [CW-1:0] wcnt;
    logic wipe_done;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] imsk;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic fl_prog;
    logic fl_erase;
    logic fl_full;
    logic [PW-1:0] fl_page;
    logic dbg_ack;
    logic dbg_deny;
    logic ffp_ack;
    logic ffp_deny;
  } fpnvm_reg_t;

  fpnvm_reg_t q_ff;
  fpnvm_reg_t nxt_q;
  fpnvm_op_t op;
  logic [PW-1:0] arg;
  logic [LW-1:0] idx;
  logic hit;
  logic apb_wr;
  logic apb_cmd;
  logic ffp_go;
  logic wipe_go;
  logic [IRQ_W-1:0] ev;

  function automatic fpnvm_op_t ffp_map(input logic [2:0] c);
    case (c)
      FF_PROG: ffp_map = OP_PROG;
      FF_ERASE: ffp_map = OP_ERASE;
      FF_FULL: ffp_map = OP_FULL;
      FF_LOCK: ffp_map = OP_SET_LOCK;
      FF_UNLOCK: ffp_map = OP_CLR_LOCK;
      FF_PROTECT: ffp_map = OP_SET_SEC;
      default: ffp_map = OP_READ;
    endcase
  endfunction : ffp_map

  // ==========================================================
  // next state
  always_comb begin
    nxt_q = q_ff;
    ev = '0;
    nxt_q.fl_prog = 1'b0;
    nxt_q.fl_erase = 1'b0;
    nxt_q.fl_full = 1'b0;
    nxt_q.dbg_ack = 1'b0;
    nxt_q.dbg_deny = 1'b0;
    nxt_q.ffp_ack = 1'b0;
    nxt_q.ffp_deny = 1'b0;

    // pins: a change counts once stages two and three agree
    nxt_q.ers_s = {q_ff.ers_s[1:0], erase_pin};
    if (q_ff.ers_s[2] == q_ff.ers_s[1]) begin
      nxt_q.ers_lvl = q_ff.ers_s[2];
    end
    nxt_q.pin_s = {q_ff.pin_s[1:0],
                   {test_mode_pin, port_a_line_zero, port_a_line_one}};
    if (q_ff.pin_s[2] == q_ff.pin_s[1]) begin
      nxt_q.mode = &q_ff.pin_s[2];
    end

    // wipe pin hold: short pulses are ignored as glitches
    if (!q_ff.ers_lvl) begin
      nxt_q.wcnt = '0;
      nxt_q.wipe_done = 1'b0;
    end else if (q_ff.wcnt != WIPE_MAX) begin
      nxt_q.wcnt = q_ff.wcnt + 1'b1;
    end
    wipe_go = q_ff.ers_lvl && q_ff.wcnt == WIPE_MAX && !q_ff.wipe_done &&
              q_ff.st == S_IDLE;

    // command sources; apb wins, the wipe beats both
    apb_wr = psel && penable && q_ff.pready && pwrite;
    apb_cmd = apb_wr && paddr == REG_CMD && q_ff.st == S_IDLE && !wipe_go;
    ffp_go = ffp_req && q_ff.mode && !q_ff.sec && !apb_cmd &&
             (q_ff.st == S_IDLE) && !wipe_go;
    if (ffp_req && !ffp_go) begin
      nxt_q.ffp_deny = 1'b1;
      ev[IRQ_DENY] = 1'b1;
    end
    if (apb_cmd) begin
      op = fpnvm_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
      arg = pwdata[CMD_ARG_LSB +: PW];
    end else if (ffp_go) begin
      op = ffp_map(ffp_cmd);
      arg = ffp_arg;
      nxt_q.ffp_ack = 1'b1;
    end else begin
      op = OP_NONE;
      arg = '0;
    end
    idx = arg[LW-1:0];
    hit = (op == OP_FULL) ? |q_ff.lock : q_ff.lock[arg[PW-1:REG_SHIFT]];

    case (op)
      OP_SET_LOCK: begin
        nxt_q.lock[idx] = 1'b1;
        ev[IRQ_DONE] = 1'b1;
      end
      OP_CLR_LOCK: begin
        nxt_q.lock[idx] = 1'b0;
        ev[IRQ_DONE] = 1'b1;
      end
      OP_SET_GP: begin
        if (32'(idx) < GP_BITS) begin
          nxt_q.gp[idx[1:0]] = 1'b1;
        end
        ev[IRQ_DONE] = 1'b1;
      end
      OP_CLR_GP: begin
        if (32'(idx) < GP_BITS) begin
          nxt_q.gp[idx[1:0]] = 1'b0;
        end
        ev[IRQ_DONE] = 1'b1;
      end
      OP_SET_SEC: begin
        nxt_q.sec = 1'b1;
        ev[IRQ_DONE] = 1'b1;
      end
      OP_PROG, OP_ERASE, OP_FULL: begin
        if (hit) begin
          ev[IRQ_ABORT] = 1'b1;
        end else begin
          nxt_q.fl_prog = op == OP_PROG;
          nxt_q.fl_erase = op == OP_ERASE;
          nxt_q.fl_full = op == OP_FULL;
          nxt_q.fl_page = arg;
          nxt_q.st = S_BUSY;
        end
      end
      default: begin
      end
    endcase

    case (q_ff.st)
      S_LOAD: begin
        // nv array contents come back after every reset
        nxt_q.lock = nv_lock_in;
        nxt_q.gp = nv_gp_in;
        nxt_q.sec = nv_sec_in;
        nxt_q.calib = nv_calib_in;
        nxt_q.st = S_IDLE;
      end
      S_IDLE: begin
        if (wipe_go) begin
          nxt_q.lock = '0;
          nxt_q.gp = '0;
          nxt_q.fl_full = 1'b1;
          nxt_q.wipe_done = 1'b1;
          nxt_q.st = S_WIPE;
        end
      end
      S_BUSY: begin
        if (flash_done) begin
          nxt_q.st = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      S_WIPE: begin
        if (flash_done) begin
          nxt_q.sec = 1'b0;
          nxt_q.st = S_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end
      end
      default: nxt_q.st = S_IDLE;
    endcase

    // debug port sees the security bit as it stands now
    if (dbg_req) begin
      nxt_q.dbg_ack = !q_ff.sec;
      nxt_q.dbg_deny = q_ff.sec;
      ev[IRQ_DENY] = ev[IRQ_DENY] | q_ff.sec;
    end

    // apb: one wait state, write acts at the pready edge
    nxt_q.pready = psel && penable && !q_ff.pready;
    nxt_q.pslverr = 1'b0;
    nxt_q.prdata = '0;
    if (nxt_q.pready) begin
      case (paddr)
        REG_CMD: nxt_q.prdata = '0;
        REG_LOCK: nxt_q.prdata[LOCKS-1:0] = q_ff.lock;
        REG_STATUS: begin
          nxt_q.prdata[ST_GP_LSB +: GP_BITS] = q_ff.gp;
          nxt_q.prdata[ST_SEC] = q_ff.sec;
          nxt_q.prdata[ST_FFP] = q_ff.mode;
          nxt_q.prdata[ST_BUSY] = q_ff.st != S_IDLE;
          nxt_q.prdata[ST_CAL_LSB +: CALIB_BITS] = q_ff.calib;
        end
        REG_IRQ_STS: nxt_q.prdata[IRQ_W-1:0] = q_ff.ists;
        REG_IRQ_MSK: nxt_q.prdata[IRQ_W-1:0] = q_ff.imsk;
        default: nxt_q.pslverr = 1'b1;
      endcase
    end
    if (apb_wr && paddr == REG_IRQ_MSK) begin
      nxt_q.imsk = pwdata[IRQ_W-1:0];
    end
    // set wins over a write-one clear in the same cycle
    if (apb_wr && paddr == REG_IRQ_STS) begin
      nxt_q.ists = q_ff.ists & ~pwdata[IRQ_W-1:0];
    end
    nxt_q.ists = nxt_q.ists | ev;
    nxt_q.irq = |(nxt_q.ists & nxt_q.imsk);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_ff <= '0;
      q_ff.imsk <= IRQ_MSK_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata = q_ff.prdata;
  assign pready = q_ff.pready;
  assign pslverr = q_ff.pslverr;
  assign irq = q_ff.irq;
  assign lock_bits = q_ff.lock;
  assign general_config_nv_bit = q_ff.gp;
  assign security_bit = q_ff.sec;
  assign calib_bits = q_ff.calib;
  assign brownout_detector_en = q_ff.gp[GP_BOD_EN];
  assign brownout_reset_en = q_ff.gp[GP_BOD_RST];
  assign boot_from_flash = q_ff.gp[GP_BOOT];
  assign flash_prog = q_ff.fl_prog;
  assign flash_erase = q_ff.fl_erase;
  assign flash_full_erase = q_ff.fl_full;
  assign flash_page = q_ff.fl_page;
  assign dbg_ack = q_ff.dbg_ack;
  assign dbg_deny = q_ff.dbg_deny;
  assign ffp_ack = q_ff.ffp_ack;
  assign ffp_deny = q_ff.ffp_deny;
  assign ffp_mode = q_ff.mode;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_lock_abort: assert property (
    (op inside {OP_PROG, OP_ERASE, OP_FULL} && hit) |=>
      q_ff.ists[IRQ_ABORT] && !q_ff.fl_prog && !q_ff.fl_erase &&
      !q_ff.fl_full && q_ff.st == $past(q_ff.st))
    else $error("locked region command not aborted");

  a_lock_set: assert property (
    op == OP_SET_LOCK |=> q_ff.lock[$past(idx)])
    else $error("set lock did not set the bit");

  a_lock_clear: assert property (
    op == OP_CLR_LOCK |=> !q_ff.lock[$past(idx)])
    else $error("clear lock did not clear the bit");

  a_wipe_clears: assert property (
    $rose(q_ff.wipe_done) |-> q_ff.lock == '0 && q_ff.gp == '0 &&
      q_ff.fl_full && q_ff.st == S_WIPE)
    else $error("wipe left locks or config bits set");

  a_wipe_hold: assert property (
    $rose(q_ff.wipe_done) |-> $past(q_ff.wcnt) == WIPE_MAX &&
      $past(q_ff.ers_lvl))
    else $error("wipe acted before the hold time");

  a_dbg_block: assert property (
    (dbg_req && q_ff.sec) |=> q_ff.dbg_deny && !q_ff.dbg_ack &&
      q_ff.ists[IRQ_DENY])
    else $error("debug access passed while secured");

  a_ffp_block: assert property (
    (ffp_req && q_ff.sec) |=> q_ff.ffp_deny && !q_ff.ffp_ack)
    else $error("fast port access passed while secured");

  a_sec_sticky: assert property (
    (q_ff.sec && q_ff.st != S_WIPE) |=> q_ff.sec)
    else $error("security bit cleared outside a wipe");

  a_sec_clear: assert property (
    $fell(q_ff.sec) |-> $past(q_ff.st) == S_WIPE && $past(flash_done))
    else $error("security cleared without wipe and erase");

  a_ffp_mode: assert property (
    q_ff.ffp_ack |-> $past(q_ff.mode) && $past(ffp_req))
    else $error("fast port served outside programming mode");

  a_calib_stable: assert property (
    q_ff.st != S_LOAD |=> $stable(q_ff.calib))
    else $error("calibration bits changed");
endmodule : fpnvm_top

// ===== fpnvm_pkg.sv
// Purpose: shared constants for the flash protection nv-bit block
// Assumes: 10 MHz system clock, APB register access
// Notes: offsets are byte addresses, one 32-bit word each
package fpnvm_pkg;
  // ==========================================================
  // timing
  localparam int CLK_KHZ = 10000;
  localparam int ERASE_HOLD_MS = 220;
  localparam int ERASE_HOLD_CYC = ERASE_HOLD_MS * CLK_KHZ;

  // ==========================================================
  // geometry
  localparam int LOCKS_PER_CTRL = 16;
  localparam int NUM_CTRL_DEF = 2;
  localparam int PAGES_PER_REGION = 64;
  localparam int PAGE_BYTES = 256;
  localparam int REG_SHIFT = $clog2(PAGES_PER_REGION);
  localparam int GP_BITS = 3;
  localparam int GP_BOD_EN = 0;
  localparam int GP_BOD_RST = 1;
  localparam int GP_BOOT = 2;
  localparam int CALIB_BITS = 8;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_LOCK = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MSK = 8'h10;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_GP_LSB = 0;
  localparam int ST_SEC = 4;
  localparam int ST_FFP = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_CAL_LSB = 8;
  localparam int IRQ_W = 3;
  localparam int IRQ_ABORT = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_DENY = 2;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 3'h0;

  // ==========================================================
  // commands
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_SET_LOCK = 4'h1, OP_CLR_LOCK = 4'h2,
    OP_SET_GP = 4'h3, OP_CLR_GP = 4'h4, OP_SET_SEC = 4'h5,
    OP_PROG = 4'h6, OP_ERASE = 4'h7, OP_FULL = 4'h8, OP_READ = 4'h9
  } fpnvm_op_t;

  typedef enum logic [2:0] {
    FF_READ = 3'h0, FF_PROG = 3'h1, FF_ERASE = 3'h2, FF_FULL = 3'h3,
    FF_LOCK = 3'h4, FF_UNLOCK = 3'h5, FF_PROTECT = 3'h6
  } fpnvm_ffp_t;

  // first state must be the reset load state
  typedef enum logic [1:0] {S_LOAD, S_IDLE, S_BUSY, S_WIPE} fpnvm_state_t;
endpackage : fpnvm_pkg

// ===== fpnvm_flash_model.sv
// Purpose: flash array stand-in that answers program and erase starts
// Assumes: start is a one-cycle pulse from the block
// Notes: slow picks a long operation, as a full erase takes
`timescale 1ns/100ps
// ==========================================================
// flash array model
module fpnvm_flash_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic slow,
  output logic flash_done
);
  logic [5:0] cnt_ff;
  // done never shares the start edge, the block would take it as the end of the new operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 6'h00;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_ff == 6'h01);
      if (start) begin
        cnt_ff <= slow ? 6'h1e : 6'h03;
      end else if (cnt_ff != 6'h00) begin
        cnt_ff <= cnt_ff - 6'h01;
      end
    end
  end
endmodule : fpnvm_flash_model

// ===== fpnvm_bench.sv
// Purpose: self-checking bench for the flash protection nv-bit block
// Assumes: short wipe hold count so the run stays brief
// Notes: apb master waits for pready, no fixed latency assumed
`timescale 1ns/100ps
// ==========================================================
// bench top
module fpnvm_bench import fpnvm_pkg::*; ;
  localparam int WIPE = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, lock_bits;
  logic pready, pslverr, irq, security_bit, bdet, brst, boot;
  logic erase_pin = 1'b0, test_mode_pin = 1'b0;
  logic port_a_line_zero = 1'b0, port_a_line_one = 1'b0;
  logic [31:0] nv_lock = 32'h8000_0001;
  logic [2:0] nv_gp = 3'h5, gp, ffp_cmd = 3'h0;
  logic [7:0] nv_calib = 8'h5a, calib;
  logic nv_sec = 1'b0, slow = 1'b0, dbg_req = 1'b0, ffp_req = 1'b0;
  logic fprog, ferase, ffull, fdone, dbg_ack, dbg_deny;
  logic ffp_ack, ffp_deny, ffp_mode;
  logic [10:0] flash_page, ffp_arg = 11'h000, last_page = 11'h000;
  logic [2:0] last_kind = 3'h0;
  int num_errors = 0, tests_run = 0, n_pulse = 0;

  fpnvm_top #(.NUM_CTRL(2), .WIPE_CYC(WIPE)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .erase_pin(erase_pin), .test_mode_pin(test_mode_pin),
    .port_a_line_zero(port_a_line_zero),
    .port_a_line_one(port_a_line_one), .nv_lock_in(nv_lock),
    .nv_gp_in(nv_gp), .nv_sec_in(nv_sec), .nv_calib_in(nv_calib),
    .lock_bits(lock_bits), .general_config_nv_bit(gp),
    .security_bit(security_bit), .calib_bits(calib),
    .brownout_detector_en(bdet), .brownout_reset_en(brst),
    .boot_from_flash(boot), .flash_prog(fprog), .flash_erase(ferase),
    .flash_full_erase(ffull), .flash_page(flash_page),
    .flash_done(fdone), .dbg_req(dbg_req), .dbg_ack(dbg_ack),
    .dbg_deny(dbg_deny), .ffp_req(ffp_req), .ffp_cmd(ffp_cmd),
    .ffp_arg(ffp_arg), .ffp_ack(ffp_ack), .ffp_deny(ffp_deny),
    .ffp_mode(ffp_mode)
  );
  fpnvm_flash_model flash (.clk(clk), .reset(reset),
    .start(fprog | ferase | ffull), .slow(slow), .flash_done(fdone));

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fprog | ferase | ffull) begin
      n_pulse <= n_pulse + 1;
      last_page <= flash_page;
      last_kind <= {ffull, ferase, fprog};
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no latency assumed: pready ends this wait, only the watchdog cuts a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic cmd(input fpnvm_op_t op, input logic [10:0] arg);
    wr(REG_CMD, ({21'h0, arg} << CMD_ARG_LSB) | {28'h0, op});
  endtask : cmd
  task automatic wait_st(input int b, input logic v);
    logic [31:0] q;
    for (int i = 0; i < 300; i++) begin
      rd(REG_STATUS, q);
      if (q[b] === v) break;
    end
    check("status wait", {31'h0, v}, {31'h0, q[b]});
  endtask : wait_st
  // one debug or fast port request, answer looked at the cycle after
  task automatic req(input logic d, input logic [2:0] c,
                     input logic [1:0] exp);
    ffp_cmd <= c;
    ffp_arg <= 11'h001;
    if (d) dbg_req <= 1'b1;
    else ffp_req <= 1'b1;
    @(posedge clk);
    dbg_req <= 1'b0;
    ffp_req <= 1'b0;
    @(posedge clk);
    check("ack deny", {30'h0, exp},
          d ? {30'h0, dbg_ack, dbg_deny} : {30'h0, ffp_ack, ffp_deny});
  endtask : req

  // ==========================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(REG_STATUS, q);
    check("status", 32'h0000_5a05, q);
    rd(REG_LOCK, q);
    check("lock", 32'h8000_0001, q);
    rd(REG_IRQ_MSK, q);
    check("irq mask", 32'h0, q);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check("unmapped", 32'h1, {31'h0, e});
    check("sys ctrl", 32'h5, {29'h0, boot, brst, bdet});
    check("calib port", 32'h5a, {24'h0, calib});
    check("config port", 32'h5, {29'h0, gp});
    $display("test reset values done");
  endtask : t_reset
  task automatic t_cmds;
    logic [31:0] q;
    cmd(OP_SET_LOCK, 11'd5);
    cmd(OP_CLR_LOCK, 11'd0);
    cmd(OP_CLR_LOCK, 11'd31);
    cmd(OP_SET_LOCK, 11'd30);
    wr(REG_LOCK, 32'h0);
    rd(REG_LOCK, q);
    check("lock", 32'h4000_0020, q);
    check("lock port", 32'h4000_0020, lock_bits);
    cmd(OP_CLR_GP, 11'd0);
    cmd(OP_SET_GP, 11'd1);
    cmd(OP_CLR_GP, 11'd2);
    rd(REG_STATUS, q);
    check("status", 32'h5a02, q);
    check("sys ctrl", 32'h2, {29'h0, boot, brst, bdet});
    $display("test lock and config commands done");
  endtask : t_cmds
  task automatic t_abort;
    logic [31:0] q;
    int n0;
    wr(REG_IRQ_STS, 32'h7);
    wr(REG_IRQ_MSK, 32'h1);
    n0 = n_pulse;
    cmd(OP_PROG, 11'h780);
    cmd(OP_ERASE, 11'h17f);
    cmd(OP_FULL, 11'h000);
    rd(REG_IRQ_STS, q);
    check("irq status", 32'h1, q);
    check("irq", 32'h1, {31'h0, irq});
    check("flash starts", n0, n_pulse);
    wr(REG_IRQ_MSK, 32'h0);
    rd(REG_IRQ_STS, q);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(REG_IRQ_STS, 32'h1);
    cmd(OP_PROG, 11'h180);
    wait_st(ST_BUSY, 1'b0);
    rd(REG_IRQ_STS, q);
    check("irq status", 32'h2, q);
    check("page", 32'h180, {21'h0, last_page});
    check("flash op", 32'h1, {29'h0, last_kind});
    check("flash starts", n0 + 1, n_pulse);
    $display("test locked abort done");
  endtask : t_abort
  task automatic t_fast;
    logic [31:0] q;
    req(1'b0, FF_READ, 2'h1);
    test_mode_pin <= 1'b1;
    port_a_line_zero <= 1'b1;
    repeat (6) @(posedge clk);
    req(1'b0, FF_READ, 2'h1);
    port_a_line_one <= 1'b1;
    repeat (6) @(posedge clk);
    check("fast mode", 32'h1, {31'h0, ffp_mode});
    for (int i = 0; i < 6; i++) begin
      req(1'b0, i[2:0], 2'h2);
      wait_st(ST_BUSY, 1'b0);
      if (i == 4) check("fast lock", 32'h4000_0022, lock_bits);
      if (i == 5) check("fast unlock", 32'h4000_0020, lock_bits);
    end
    req(1'b1, FF_READ, 2'h2);
    req(1'b0, FF_PROTECT, 2'h2);
    req(1'b0, FF_READ, 2'h1);
    req(1'b1, FF_READ, 2'h1);
    rd(REG_IRQ_STS, q);
    check("refused flag", 32'h1, {31'h0, q[IRQ_DENY]});
    cmd(OP_CLR_GP, 11'd0);
    rd(REG_STATUS, q);
    check("security", 32'h1, {31'h0, q[ST_SEC]});
    test_mode_pin <= 1'b0;
    port_a_line_zero <= 1'b0;
    port_a_line_one <= 1'b0;
    repeat (6) @(posedge clk);
    $display("test fast port and debug done");
  endtask : t_fast
  task automatic t_wipe;
    logic [31:0] q;
    int n0;
    n0 = n_pulse;
    slow <= 1'b1;
    erase_pin <= 1'b1;
    // held well past the scaled hold count
    repeat (WIPE + 20) @(posedge clk);
    erase_pin <= 1'b0;
    rd(REG_STATUS, q);
    check("security held", 32'h1, {31'h0, q[ST_SEC]});
    wait_st(ST_SEC, 1'b0);
    rd(REG_STATUS, q);
    check("status", 32'h5a00, q);
    check("lock port", 32'h0, lock_bits);
    check("full erase", n0 + 1, n_pulse);
    check("flash op", 32'h4, {29'h0, last_kind});
    check("calib port", 32'h5a, {24'h0, calib});
    check("sys ctrl", 32'h0, {29'h0, boot, brst, bdet});
    req(1'b1, FF_READ, 2'h2);
    slow <= 1'b0;
  endtask : t_wipe
  task automatic t_security;
    logic [31:0] q;
    t_wipe;
    cmd(OP_SET_SEC, 11'd0);
    rd(REG_STATUS, q);
    check("security", 32'h1, {31'h0, security_bit});
    req(1'b1, FF_READ, 2'h1);
    t_wipe;
    $display("test wipe and security done");
  endtask : t_security

  // ==========================================================
  // run control
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_cmds;
    t_abort;
    t_fast;
    t_security;
    complete_run;
  end
  // a hang is cut well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run;
  end
endmodule : fpnvm_bench
